// ==== core/async_serial_interface.sv ====
// asynchronous serial interface with apb register access
// How it works
// - word length eight or nine bits
// - start low, stop high, lsb first
// - idle frame is one frame of ones
// - extra high bit after last break
// - separate tx and rx baud generators
// - ninth transmit bit from tx_ninth
// - tx_on claims pin, sends idle first
// - status then data write clears tx flags
// - write while busy waits in holding buffer
// - write while idle starts at once
// - tx_done at frame end, optional interrupt
// - interrupt while buffer empty and enabled
// - break frames while break control set
// - tx_on toggle: idle frame, drop held data
// - receive lsb first, ninth to rx_ninth
// - rx_on starts start bit search
// - completed character fills rx buffer
// - status then data read clears rx_full
// - idle line acts as received character
// - overrun keeps buffer, flags, interrupts
// - majority sampling flags noise, no interrupt
// - bad stop or break sets framing flag
// - baud is clock over 32, prescale, divisor
//
// Added by the designer: the APB interface to the registers and the address map.
`include "async_serial_defines.svh"
module async_serial_interface (
    // clock and reset
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    // apb slave
    input  wire async_serial_pkg::apb_req_t apbReq,
    output logic                           pready,
    output logic [31:0]                    prdata,
    output logic                           pslverr,
    // cpu global interrupt mask, high masks
    input  wire logic                      irqMask,
    output logic                           irqReq,
    // serial pins
    output logic                           txPin,
    output logic                           txOeN,
    input  wire logic                      rxPin
);
    import async_serial_pkg::*;

    state_t     s;          // registered state
    state_t     n;          // next state
    logic [1:0] rstPipe_ff; // reset release synchroniser
    logic       rstn;       // synchronised reset

    // prescale multiplier from its two-bit select
    function automatic logic [3:0] preMul(input logic [1:0] sel);
        unique case (sel)
            2'h0: preMul = 4'h1;
            2'h1: preMul = 4'h3;
            2'h2: preMul = 4'h4;
            default: preMul = 4'hd;
        endcase
    endfunction

    // clocks per tick minus one: per-bit base scaled by prescale and power of two
    function automatic logic [15:0] tickLim(input logic [1:0] pr, input logic [2:0] dv,
                                            input logic [5:0] base);
        // widen first: a six-bit product would wrap before the shift
        tickLim = ((16'(base) * 16'(preMul(pr))) << dv) - 16'h1;
    endfunction

    // address match for the register map
    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // release reset through two flops; assertion is still immediate
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstPipe_ff <= 2'h0;
        end else begin
            rstPipe_ff <= {rstPipe_ff[0], 1'b1};
        end
    end
    assign rstn = rstPipe_ff[1];

    logic       setupCyc;  // apb setup phase
    logic       accCyc;    // apb access completes this edge
    logic       dataWr;    // accepted data port write
    logic       dataRd;    // accepted data port read
    logic       txOn;      // transmitter enable
    logic       rxOn;      // receiver enable
    logic       txTick;    // one tx bit period elapsed
    logic       rxTick;    // one rx oversample elapsed
    logic       choose;    // pick the next tx frame now
    logic [3:0] frameLen;  // bits per frame incl. start and stop
    logic [3:0] dataBits;  // data bits per frame
    logic       bitVal;    // majority of three samples
    logic [10:0] nxtFrame; // frame being loaded

    assign setupCyc = apbReq.psel && !apbReq.penable;
    assign accCyc   = apbReq.psel && apbReq.penable && s.pready;
    assign dataWr   = accCyc && apbReq.pwrite && hit(apbReq.paddr, `OFF_DATA);
    assign dataRd   = accCyc && !apbReq.pwrite && hit(apbReq.paddr, `OFF_DATA);
    assign txOn     = s.ctlTwo[`C2_TX_ON];
    assign rxOn     = s.ctlTwo[`C2_RX_ON];
    assign txTick   = s.txBusy && (s.txDiv == 16'h0);
    assign rxTick   = rxOn && (s.rxDiv == 16'h0);
    assign choose   = !s.txBusy || (txTick && (s.txLeft == 4'h0));
    assign frameLen = s.nineBit ? `LEN9 : `LEN8;
    assign dataBits = frameLen - 4'h2;
    assign bitVal   = (s.rxSmp[1] & s.rxSmp[0]) | (s.rxSmp[1] & rxPin) | (s.rxSmp[0] & rxPin);

    // next-state logic for bus, transmitter and receiver
    always_comb begin
        n = s;
        nxtFrame = 11'h0;
        // apb: answer one cycle after setup, read data captured then
        n.pready = setupCyc;
        if (setupCyc) begin
            n.pslverr = 1'b0;
            n.prdata  = 32'h0;
            if (hit(apbReq.paddr, `OFF_STAT)) begin
                n.prdata[7:0] = {s.txEmpty, s.txDone, s.rxFull, s.idleFlag,
                                 s.overrun, s.noise, s.framing, 1'b0};
            end else if (hit(apbReq.paddr, `OFF_DATA)) begin
                n.prdata[7:0] = s.rxHold;
            end else if (hit(apbReq.paddr, `OFF_CTL_ONE)) begin
                n.prdata[`C1_RXNINTH] = s.rxNinth;
                n.prdata[`C1_TXNINTH] = s.txNinth;
                n.prdata[`C1_NINEBIT] = s.nineBit;
            end else if (hit(apbReq.paddr, `OFF_CTL_TWO)) begin
                n.prdata[7:0] = s.ctlTwo;
            end else if (hit(apbReq.paddr, `OFF_BAUD)) begin
                n.prdata[7:0] = s.baud;
            end else begin
                n.pslverr = 1'b1; // unmapped
            end
        end
        if (accCyc) begin
            n.statRead = !apbReq.pwrite && hit(apbReq.paddr, `OFF_STAT) ? 1'b1 :
                         (hit(apbReq.paddr, `OFF_DATA) ? 1'b0 : s.statRead);
        end
        if (accCyc && apbReq.pwrite) begin
            if (hit(apbReq.paddr, `OFF_CTL_ONE)) begin
                n.txNinth = apbReq.pwdata[`C1_TXNINTH];
                n.nineBit = apbReq.pwdata[`C1_NINEBIT];
            end
            if (hit(apbReq.paddr, `OFF_CTL_TWO)) begin
                n.ctlTwo = apbReq.pwdata[7:0];
            end
            if (hit(apbReq.paddr, `OFF_BAUD)) begin
                n.baud = apbReq.pwdata[7:0];
            end
        end
        // ordered access clears tx flags; hardware sets below win
        if (dataWr) begin
            n.txHold = {s.txNinth, apbReq.pwdata[7:0]};
            if (s.statRead) begin
                n.txEmpty = 1'b0;
                n.txDone  = 1'b0;
            end
        end
        if (dataRd && s.statRead) begin
            n.rxFull   = 1'b0;
            n.idleFlag = 1'b0;
            n.overrun  = 1'b0;
            n.noise    = 1'b0;
            n.framing  = 1'b0;
        end

        n.txDiv = !s.txBusy ? 16'h0 :
                  (txTick ? tickLim(s.baud[1:0], s.baud[4:2], 6'(`CLK_PER_BIT))
                          : s.txDiv - 16'h1);
        // enable edge queues idle, drops held word
        n.txOnPrev = txOn;
        if (txOn && !s.txOnPrev) begin
            n.idlePend = 1'b1;
            n.txEmpty  = 1'b1;
        end
        if (s.txBusy && choose && !s.txExtra) begin
            n.txDone = 1'b1;
        end
        if (choose) begin
            n.txBusy  = 1'b1;
            n.txExtra = 1'b0;
            n.txLeft  = frameLen;
            if (!txOn) begin
                n.txBusy = 1'b0;
            end else if (n.idlePend) begin
                nxtFrame   = '1;
                n.idlePend = 1'b0;
            end else if (s.ctlTwo[`C2_BREAK]) begin
                nxtFrame   = 11'h0;
                n.wasBreak = 1'b1;
            end else if (s.wasBreak) begin
                nxtFrame   = '1;
                n.txLeft   = 4'h1;
                n.txExtra  = 1'b1;
                n.wasBreak = 1'b0;
            end else if (!n.txEmpty || (dataWr && !s.txBusy)) begin
                // start 0, data lsb first, ninth, stop 1
                nxtFrame  = s.nineBit ? {1'b1, n.txHold, 1'b0}
                                      : {2'b11, n.txHold[7:0], 1'b0};
                n.txEmpty = 1'b1;
            end else begin
                n.txBusy = 1'b0;
            end
            n.txSh = nxtFrame;
        end
        // shift one bit out per tick; a frame chosen on a tick starts at once,
        // otherwise the last bit of every frame would stand two bit times
        if (txTick && n.txBusy && n.txLeft != 4'h0) begin
            n.txPin  = n.txSh[0];
            n.txSh   = {1'b1, n.txSh[10:1]};
            n.txLeft = n.txLeft - 4'h1;
        end
        if (!n.txBusy) begin
            n.txPin = 1'b1;
        end
        // pin belongs to the serial function while enabled or sending
        n.txOeN = !(txOn || n.txBusy);

        // rx oversample timer, sixteen per bit
        n.rxDiv = !rxOn ? 16'h0 :
                  (rxTick ? tickLim(s.baud[1:0], s.baud[7:5], 6'(`CLK_PER_BIT / `OVS))
                          : s.rxDiv - 16'h1);
        if (rxTick) begin
            n.rxSmp = {s.rxSmp[0], rxPin};
            unique case (s.rxSt)
                RX_HUNT: begin
                    if (!rxPin) begin
                        n.rxSt    = RX_START;
                        n.rxPh    = 4'h0;
                        n.idleCnt = 8'h0;
                    end else if (s.idleCnt == 8'(frameLen * `OVS) - 8'h1) begin
                        // full frame of ones after a character
                        if (s.idleArmed) begin
                            n.idleFlag  = 1'b1;
                            n.rxFull    = 1'b1;
                            n.idleArmed = 1'b0;
                        end
                    end else begin
                        n.idleCnt = s.idleCnt + 8'h1;
                    end
                end
                RX_START: begin
                    // confirm start at mid bit, else treat as glitch
                    n.rxPh = s.rxPh + 4'h1;
                    if (s.rxPh == `OVS_HALF) begin
                        n.rxSt    = rxPin ? RX_HUNT : RX_DATA;
                        n.rxPh    = 4'h0;
                        n.rxIdx   = 4'h0;
                        n.rxNoise = 1'b0;
                    end
                end
                RX_DATA: begin
                    n.rxPh = s.rxPh + 4'h1;
                    if (s.rxPh == `OVS_LAST) begin
                        if ((s.rxSmp != {2{rxPin}})) begin
                            n.rxNoise = 1'b1;
                        end
                        n.rxIdx = s.rxIdx + 4'h1;
                        if (s.rxIdx < dataBits) begin
                            // lsb first into top of shifter
                            n.rxSh = {bitVal, s.rxSh[8:1]};
                        end else begin
                            n.rxSt    = RX_HUNT;
                            n.idleCnt = 8'h0;
                            if (s.rxFull) begin
                                n.overrun = 1'b1;
                            end else begin
                                n.rxHold    = s.nineBit ? s.rxSh[7:0] : s.rxSh[8:1];
                                n.rxNinth   = s.nineBit ? s.rxSh[8] : s.rxNinth;
                                n.rxFull    = 1'b1;
                                n.idleArmed = 1'b1;
                                n.noise     = n.rxNoise;
                                n.framing   = !bitVal;
                            end
                        end
                    end
                end
            endcase
        end
        // disabled receiver rests hunting with flags cleared
        if (!rxOn) begin
            n.rxSt     = RX_HUNT;
            n.idleCnt  = 8'h0;
            n.rxFull   = 1'b0;
            n.idleFlag = 1'b0;
            n.overrun  = 1'b0;
            n.noise    = 1'b0;
            n.framing  = 1'b0;
        end
        // enabled events, gated by cpu mask
        n.irq = !irqMask &&
                ((s.ctlTwo[`C2_TXE_IE] && n.txEmpty) || (s.ctlTwo[`C2_DONE_IE] && n.txDone) ||
                 (s.ctlTwo[`C2_RX_IE] && (n.rxFull || n.overrun)) ||
                 (s.ctlTwo[`C2_IDLE_IE] && n.idleFlag));
    end

    // single state register; status resets with tx buffer empty and done
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s         <= '0;
            s.txEmpty <= 1'(`STAT_RESET >> `STAT_TXE_BIT);
            s.txDone  <= 1'(`STAT_RESET >> `STAT_DONE_BIT);
            s.txPin   <= 1'b1;
            s.txOeN   <= 1'b1;
            s.rxSt    <= RX_HUNT;
        end else begin
            s <= n;
        end
    end

    assign pready  = s.pready;
    assign prdata  = s.prdata;
    assign pslverr = s.pslverr;
    assign irqReq  = s.irq;
    assign txPin   = s.txPin;
    assign txOeN   = s.txOeN;

    // checks
    sequence seqStatRead;
        accCyc && !apbReq.pwrite && hit(apbReq.paddr, `OFF_STAT);
    endsequence
    sequence seqClearWr;
        s.statRead && dataWr && s.txBusy && !txTick;
    endsequence

    AST_IDLE_LINE_HIGH: assert property (@(posedge core_clk) disable iff (!rstn)
        !s.txBusy |-> s.txPin) else $error("line not high while idle");
    AST_DIRECT_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
        dataWr && !s.txBusy && txOn && s.txOnPrev && !s.idlePend && !s.wasBreak
        && !s.ctlTwo[`C2_BREAK] |=> s.txEmpty && s.txBusy ##1 !s.txPin)
        else $error("idle write did not start frame");
    AST_TXE_IRQ: assert property (@(posedge core_clk) disable iff (!rstn)
        s.txEmpty && $past(s.ctlTwo[`C2_TXE_IE]) && !$past(irqMask) |-> irqReq)
        else $error("empty buffer gave no interrupt");
    AST_CLEAR_TX: assert property (@(posedge core_clk) disable iff (!rstn)
        seqClearWr |=> !s.txDone) else $error("done flag not cleared");
    AST_STAT_MEMO: assert property (@(posedge core_clk) disable iff (!rstn)
        seqStatRead |=> s.statRead) else $error("status read not remembered");
    AST_RX_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
        !rxOn |=> !s.rxFull && s.rxSt == RX_HUNT) else $error("disabled receiver active");
    AST_OVERRUN_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(s.overrun) |-> $stable(s.rxHold) && s.rxFull) else $error("overrun lost data");
    AST_NOISE_WITH_FULL: assert property (@(posedge core_clk) disable iff (!rstn)
        $rose(s.noise) |-> $rose(s.rxFull)) else $error("noise without full");
    // end of any data, idle or break frame marks done
    AST_DONE_AT_END: assert property (@(posedge core_clk) disable iff (!rstn)
        s.txBusy && txTick && s.txLeft == 4'h0 && !s.txExtra |=> s.txDone)
        else $error("frame end did not set done");
    // held word follows the frame in flight without a gap
    AST_HELD_LOAD: assert property (@(posedge core_clk) disable iff (!rstn)
        s.txBusy && txTick && s.txLeft == 4'h0 && !s.txEmpty && txOn && s.txOnPrev
        && !s.idlePend && !s.wasBreak && !s.ctlTwo[`C2_BREAK] |=> s.txEmpty && !s.txPin)
        else $error("held word not started at frame end");
endmodule

// ==== core/async_serial_defines.svh ====
// constants for the asynchronous serial interface: offsets, fields, reset values, timing
`ifndef ASYNC_SERIAL_DEFINES_SVH
`define ASYNC_SERIAL_DEFINES_SVH
`define OFF_STAT      12'h000
`define OFF_DATA      12'h004
`define OFF_CTL_ONE   12'h008
`define OFF_CTL_TWO   12'h00c
`define OFF_BAUD      12'h010
`define STAT_RESET    8'hc0
`define STAT_TXE_BIT  7
`define STAT_DONE_BIT 6
`define C1_RXNINTH    7
`define C1_TXNINTH    6
`define C1_NINEBIT    4
`define C2_TXE_IE     7
`define C2_DONE_IE    6
`define C2_RX_IE      5
`define C2_IDLE_IE    4
`define C2_TX_ON      3
`define C2_RX_ON      2
`define C2_BREAK      0
`define CLK_PER_BIT   32
`define OVS           16
`define OVS_HALF      4'h7
`define OVS_LAST      4'hf
`define LEN8          4'ha
`define LEN9          4'hb
`endif

// ==== core/async_serial_pkg.sv ====
// types shared by the asynchronous serial interface
package async_serial_pkg;
    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;
    // receiver sequencing
    typedef enum logic [2:0] {
        RX_HUNT  = 3'b001,
        RX_START = 3'b010,
        RX_DATA  = 3'b100
    } rx_state_t;
    // whole block state
    typedef struct packed {
        logic [7:0]  ctlTwo;   // enables and break
        logic        txNinth;  // ninth bit to send
        logic        nineBit;  // word length select
        logic [7:0]  baud;     // [1:0] prescale, [4:2] tx div, [7:5] rx div
        logic        txEmpty;
        logic        txDone;
        logic        rxFull;
        logic        idleFlag;
        logic        overrun;
        logic        noise;
        logic        framing;
        logic        statRead; // status read awaiting data access
        logic [7:0]  rxHold;
        logic        rxNinth;
        logic [8:0]  txHold;
        logic [15:0] txDiv;
        logic        txBusy;
        logic [10:0] txSh;
        logic [3:0]  txLeft;
        logic        txExtra;  // current frame is the post-break one bit
        logic        txOnPrev;
        logic        idlePend;
        logic        wasBreak;
        logic        txPin;
        logic        txOeN;
        logic [15:0] rxDiv;
        rx_state_t   rxSt;
        logic [3:0]  rxPh;
        logic [3:0]  rxIdx;
        logic [1:0]  rxSmp;
        logic [8:0]  rxSh;
        logic        rxNoise;
        logic [7:0]  idleCnt;
        logic        idleArmed;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
    } state_t;
endpackage

// ==== test/serial_peer.sv ====
// serial line partner: drives the receive line, captures the transmit line
`include "async_serial_defines.svh"
module serial_peer (
    // clock
    input  wire logic core_clk,
    // lines
    input  wire logic txPin,
    output logic      rxPin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial rxPin = 1'b1; // line marks high between frames
    int noiseBit = -2;    // data bit that gets one bad sample, none by default
    // start low, data lsb first, stop
    task automatic send_frame(input logic [8:0] d, input int nb, input logic stopV);
        for (int i = -1; i <= nb; i++) begin
            @(posedge core_clk);
            rxPin <= (i < 0) ? 1'b0 : (i == nb) ? stopV : d[i];
            if (i == noiseBit) begin
                // two-cycle inverse pulse hits one of the three samples
                repeat (15) @(posedge core_clk);
                rxPin <= ~d[i];
                repeat (2) @(posedge core_clk);
                rxPin <= d[i];
                repeat (`CLK_PER_BIT - 18) @(posedge core_clk);
            end else begin
                repeat (`CLK_PER_BIT - 1) @(posedge core_clk);
            end
        end
        @(posedge core_clk);
        rxPin <= 1'b1;
    endtask
    // measure start, sample mid bit; bit 0 must be 1
    task automatic grab_frame(input int nb, input int bc, output logic [8:0] d,
                              output logic stopV, output int startLen);
        d = '0;
        startLen = 0;
        while (txPin !== 1'b0) @(posedge core_clk);
        while (txPin === 1'b0 && startLen < 12 * bc) begin
            @(posedge core_clk);
            startLen++;
        end
        repeat (bc / 2) @(posedge core_clk);
        for (int i = 0; i < nb; i++) begin
            d[i] = txPin;
            repeat (bc) @(posedge core_clk);
        end
        stopV = txPin;
    endtask
endmodule

// ==== test/tb.sv ====
// self-checking bench for the asynchronous serial interface
`include "async_serial_defines.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import async_serial_pkg::*;
    logic        core_clk = 1'b0;
    logic        resetn;
    apb_req_t    apbReq;
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
    logic        irqMask;
    logic        irqReq;
    logic        txPin;
    logic        txOeN;
    logic        rxPin;
    int          err_total = 0;
    int          samples_checked = 0;
    int          cyc = 0;   // free cycle count
    logic [31:0] rd;        // last read data
    logic        er;        // last error flag
    logic [8:0]  fr;        // captured word
    logic        stp;       // captured stop level
    int          sl;        // start low length
    async_serial_interface dut_u (.core_clk(core_clk), .resetn(resetn), .apbReq(apbReq),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .irqMask(irqMask),
        .irqReq(irqReq), .txPin(txPin), .txOeN(txOeN), .rxPin(rxPin));
    serial_peer peer_u (.core_clk(core_clk), .txPin(txPin), .rxPin(rxPin));
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) cyc <= cyc + 1;
    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; held until pready is sampled high
    task automatic apb(input int wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: 1'(wr), paddr: a, pwdata: d};
        @(posedge core_clk);
        apbReq.penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (n >= 16) check("pready", 32'h1, 32'h0);
    endtask
    task automatic test_regs();
        apb(0, `OFF_STAT, 0);
        check("status reset", 32'hc0, rd);
        apb(0, 12'h014, 0);
        check("unmapped err", 32'h1, {31'h0, er});
        check("unmapped data", 32'h0, rd);
        $display("regs done");
    endtask
    task automatic test_tx8();
        int t0;
        apb(1, `OFF_BAUD, 0);
        apb(1, `OFF_CTL_TWO, 32'h08);
        t0 = cyc;
        apb(0, `OFF_STAT, 0);
        apb(1, `OFF_DATA, 32'ha5);
        apb(0, `OFF_STAT, 0);
        check("held", 32'h0, {31'h0, rd[7]});
        check("pin claimed", 32'h0, {31'h0, txOeN});
        peer_u.grab_frame(8, 32, fr, stp, sl);
        check("idle lead", 32'h1, {31'h0, (cyc - t0) >= 620});
        check("word", 32'ha5, {23'h0, fr});
        check("stop", 32'h1, {31'h0, stp});
        check("bit time", 32, sl);
        repeat (40) @(posedge core_clk);
        apb(0, `OFF_STAT, 0);
        check("done flags", 32'h3, {30'h0, rd[7:6]});
        apb(1, `OFF_DATA, 32'h81);
        apb(0, `OFF_STAT, 0);
        check("direct load", 32'h2, {30'h0, rd[7:6]});
        peer_u.grab_frame(8, 32, fr, stp, sl);
        check("word2", 32'h81, {23'h0, fr});
        repeat (40) @(posedge core_clk);
        apb(1, `OFF_CTL_TWO, 32'h88);
        repeat (3) @(posedge core_clk);
        check("empty irq", 32'h1, {31'h0, irqReq});
        irqMask <= 1'b1;
        repeat (3) @(posedge core_clk);
        check("masked", 32'h0, {31'h0, irqReq});
        irqMask <= 1'b0;
        apb(1, `OFF_CTL_TWO, 32'h48);
        repeat (3) @(posedge core_clk);
        check("done irq", 32'h1, {31'h0, irqReq});
        apb(1, `OFF_CTL_TWO, 0);
        $display("tx8 done");
    endtask
    task automatic test_tx9();
        apb(1, `OFF_BAUD, 32'h04);
        apb(1, `OFF_CTL_ONE, 32'h50);
        apb(1, `OFF_CTL_TWO, 32'h08);
        apb(0, `OFF_STAT, 0);
        apb(1, `OFF_DATA, 32'h3d);
        peer_u.grab_frame(9, 64, fr, stp, sl);
        check("ninth word", 32'h13d, {23'h0, fr});
        check("slow bit", 64, sl);
        check("stop9", 32'h1, {31'h0, stp});
        repeat (80) @(posedge core_clk);
        apb(1, `OFF_CTL_TWO, 0);
        apb(1, `OFF_BAUD, 0);
        apb(1, `OFF_CTL_ONE, 0);
        $display("tx9 done");
    endtask
    task automatic test_break();
        apb(1, `OFF_CTL_TWO, 32'h09);
        fork
            peer_u.grab_frame(0, 32, fr, stp, sl);
            begin
                wait (txPin === 1'b0);
                apb(1, `OFF_CTL_TWO, 32'h08);
            end
        join
        check("break len", 320, sl);
        check("extra one", 32'h1, {31'h0, stp});
        repeat (40) @(posedge core_clk);
        $display("break done");
    endtask
    task automatic test_rx();
        apb(1, `OFF_CTL_TWO, 32'h24);
        peer_u.send_frame(9'h05a, 8, 1'b1);
        repeat (20) @(posedge core_clk);
        check("rx irq", 32'h1, {31'h0, irqReq});
        apb(0, `OFF_STAT, 0);
        check("rx full", 32'h20, rd & 32'h3e);
        apb(0, `OFF_DATA, 0);
        check("rx data", 32'h5a, rd);
        apb(0, `OFF_STAT, 0);
        check("rx clear", 32'h0, {31'h0, rd[5]});
        repeat (400) @(posedge core_clk);
        apb(0, `OFF_STAT, 0);
        check("idle", 32'h30, rd & 32'h3e);
        apb(0, `OFF_DATA, 0);
        apb(1, `OFF_CTL_ONE, 32'h10);
        peer_u.send_frame(9'h1a3, 9, 1'b1);
        repeat (20) @(posedge core_clk);
        apb(0, `OFF_CTL_ONE, 0);
        check("rx ninth", 32'h1, {31'h0, rd[7]});
        apb(0, `OFF_STAT, 0);
        apb(0, `OFF_DATA, 0);
        check("rx9 data", 32'ha3, rd);
        apb(1, `OFF_CTL_ONE, 0);
        $display("rx done");
    endtask
    task automatic test_err();
        peer_u.send_frame(9'h011, 8, 1'b1);
        peer_u.send_frame(9'h022, 8, 1'b1);
        repeat (20) @(posedge core_clk);
        apb(0, `OFF_STAT, 0);
        check("overrun", 32'h28, rd & 32'h2e);
        apb(0, `OFF_DATA, 0);
        check("kept", 32'h11, rd);
        peer_u.send_frame(9'h033, 8, 1'b0);
        repeat (20) @(posedge core_clk);
        apb(0, `OFF_STAT, 0);
        check("framing", 32'h22, rd & 32'h2e);
        apb(0, `OFF_DATA, 0);
        check("bad stop data", 32'h33, rd);
        peer_u.noiseBit = 1;
        peer_u.send_frame(9'h044, 8, 1'b1);
        peer_u.noiseBit = -2;
        repeat (20) @(posedge core_clk);
        apb(0, `OFF_STAT, 0);
        check("noise", 32'h24, rd & 32'h2e);
        apb(0, `OFF_DATA, 0);
        check("noisy data", 32'h44, rd);
        $display("errors done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        apbReq = '0;
        resetn = 1'b0;
        irqMask = 1'b0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        test_regs();
        test_tx8();
        test_tx9();
        test_break();
        test_rx();
        test_err();
        report_and_stop();
    end
    // watchdog, well beyond the roughly 6000 cycles of traffic
    initial begin
        #800000;
        err_total++;
        report_and_stop();
    end
endmodule
